// ==== rtl/bme_pkg.sv ====
// package for the branch / multiply execution unit: opcodes, request and
// result carriers, status bit positions and cycle counts.
// assumes the surrounding core decodes instructions and supplies operands.
package bme_pkg;

	localparam int PC_W = 16;

	// status_flags_register bit positions
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;

	// cycle counts
	localparam logic [2:0] CYC_PRODUCT   = 3'h2;
	localparam logic [2:0] CYC_JUMP_REL  = 3'h2;
	localparam logic [2:0] CYC_JUMP_FAR  = 3'h3;
	localparam logic [2:0] CYC_CALL_NEAR = 3'h3;
	localparam logic [2:0] CYC_CALL_FAR  = 3'h4;
	localparam logic [2:0] CYC_EXIT      = 3'h4;
	localparam logic [2:0] CYC_CMP       = 3'h1;
	localparam logic [2:0] CYC_BR_NOT    = 3'h1;
	localparam logic [2:0] CYC_BR_TAKEN  = 3'h2;
	localparam logic [2:0] CYC_SKIP_ONE  = 3'h2;
	localparam logic [2:0] CYC_SKIP_TWO  = 3'h3;

	localparam logic [PC_W-1:0] PC_STEP_ONE = 16'h0001;
	localparam logic [PC_W-1:0] PC_STEP_TWO = 16'h0002;
	localparam logic [PC_W-1:0] PC_STEP_THR = 16'h0003;
	localparam logic [7:0]      FLAGS_RESET = 8'h00;

	typedef enum logic [5:0] {
		op_product_unsigned, op_product_signed, op_product_signed_by_unsigned,
		op_fractional_product_unsigned, op_fractional_product_signed,
		op_fractional_product_mixed,
		op_relative_jump, op_pointer_jump, op_absolute_jump,
		op_relative_subroutine_entry, op_pointer_subroutine_entry, op_direct_subroutine_entry,
		op_subroutine_exit, op_handler_exit,
		op_equal_compare_skip, op_register_compare, op_compare_with_borrow,
		op_immediate_compare,
		op_skip_reg_bit_clear, op_skip_reg_bit_high, op_skip_io_bit_clear, op_skip_io_bit_high,
		op_branch_flag_high, op_branch_flag_low, op_branch_on_equal, op_branch_on_unequal,
		op_branch_carry_high, op_branch_carry_low, op_branch_same_or_higher, op_branch_lower,
		op_branch_negative, op_branch_positive, op_branch_signed_ge, op_branch_signed_lt,
		op_branch_halfcarry_high, op_branch_halfcarry_low
	} bme_op_type;

	typedef struct packed {
		bme_op_type      op;
		logic [7:0]      rd_val;
		logic [7:0]      rr_val;
		logic [7:0]      imm;
		logic [2:0]      bit_sel;
		logic [11:0]     offset;
		logic [PC_W-1:0] abs_addr;
		logic [PC_W-1:0] z_ptr;
		logic [PC_W-1:0] pc;
		logic [7:0]      flags;
		logic [7:0]      io_val;
		logic [PC_W-1:0] stack_pc;
		logic            next_two_word;
	} bme_req_type;

	typedef struct packed {
		logic [PC_W-1:0] pc;
		logic [7:0]      flags;
		logic [15:0]     product;
		logic            prod_we;
		logic            push_en;
		logic [PC_W-1:0] push_addr;
		logic            pop_en;
	} bme_res_type;

endpackage

// ==== rtl/bme_mult.sv ====
// 8x8 multiplier with signed/unsigned operand selection and fractional shift.
// assumes operands are stable for the cycle in which the result is taken.
`timescale 1ns/100ps
module bme_mult import bme_pkg::*; (
	input  wire logic [7:0]  a,
	input  wire logic [7:0]  b,
	input  wire logic        a_signed,
	input  wire logic        b_signed,
	input  wire logic        frac,
	output logic      [15:0] prod,
	output logic             zero,
	output logic             carry
);

	logic signed [8:0]  ext_a;
	logic signed [8:0]  ext_b;
	logic signed [17:0] full;
	logic        [15:0] raw;

	always_comb begin
		ext_a = $signed({a_signed & a[7], a});
		ext_b = $signed({b_signed & b[7], b});
		full  = ext_a * ext_b;
		raw   = full[15:0];
		// carry is the top bit before the fractional shift
		carry = raw[15];
		prod  = frac ? {raw[14:0], 1'b0} : raw;
		zero  = (prod == 16'h0000);
	end

endmodule

// ==== rtl/bme_exec.sv ====
// execution unit for multiply, jump, call, return, compare, skip and branch.
// assumes the core holds START until accepted and operands valid with it.
`timescale 1ns/100ps
module bme_exec import bme_pkg::*; (
	input  wire logic        REF_CLK,
	input  wire logic        RST,
	input  wire logic        START,
	input  wire bme_req_type REQ,
	output logic             BUSY,
	output logic             DONE,
	output bme_res_type      RES
);

	logic        busy;
	logic        done;
	logic [1:0]  cnt;
	bme_res_type res;
	logic        next_busy;
	logic        next_done;
	logic [1:0]  next_cnt;
	bme_res_type next_res;

	logic            accept;
	logic [15:0]     m_prod;
	logic            m_zero;
	logic            m_carry;
	logic            m_asig;
	logic            m_bsig;
	logic            m_frac;
	logic [PC_W-1:0] rel_target;
	logic            br_taken;
	logic            skip_cond;
	logic [2:0]      cyc;

	function automatic logic [7:0] compare_flags(input logic [7:0] flags_in,
		input logic [7:0] d, input logic [7:0] r, input logic use_c);
		logic [7:0] f;
		logic [7:0] diff;
		f    = flags_in;
		diff = d - r - {7'h00, use_c & flags_in[FLAG_C]};
		f[FLAG_H] = (~d[3] & r[3]) | (r[3] & diff[3]) | (diff[3] & ~d[3]);
		f[FLAG_V] = (d[7] & ~r[7] & ~diff[7]) | (~d[7] & r[7] & diff[7]);
		f[FLAG_N] = diff[7];
		f[FLAG_C] = (~d[7] & r[7]) | (r[7] & diff[7]) | (diff[7] & ~d[7]);
		f[FLAG_S] = f[FLAG_N] ^ f[FLAG_V];
		// with borrow, zero only stays set if it already was
		f[FLAG_Z] = (diff == 8'h00) & (~use_c | flags_in[FLAG_Z]);
		return f;
	endfunction

	function automatic logic branch_cond(input bme_op_type op, input logic [7:0] s,
		input logic [2:0] sel);
		logic t;
		t = 1'b0;
		unique case (op)
			op_branch_flag_high: t = s[sel];
			op_branch_flag_low: t = ~s[sel];
			op_branch_on_equal: t = s[FLAG_Z];
			op_branch_on_unequal: t = ~s[FLAG_Z];
			op_branch_carry_high, op_branch_lower: t = s[FLAG_C];
			op_branch_carry_low, op_branch_same_or_higher: t = ~s[FLAG_C];
			op_branch_negative: t = s[FLAG_N];
			op_branch_positive: t = ~s[FLAG_N];
			op_branch_signed_ge: t = ~(s[FLAG_N] ^ s[FLAG_V]);
			op_branch_signed_lt: t = s[FLAG_N] ^ s[FLAG_V];
			op_branch_halfcarry_high: t = s[FLAG_H];
			op_branch_halfcarry_low: t = ~s[FLAG_H];
			default: t = 1'b0;
		endcase
		return t;
	endfunction

	assign accept     = START & ~busy;
	assign rel_target = REQ.pc + {{4{REQ.offset[11]}}, REQ.offset} + PC_STEP_ONE;
	assign br_taken   = branch_cond(REQ.op, REQ.flags, REQ.bit_sel);

	always_comb begin
		unique case (REQ.op)
			op_equal_compare_skip: skip_cond = (REQ.rd_val == REQ.rr_val);
			op_skip_reg_bit_clear: skip_cond = ~REQ.rr_val[REQ.bit_sel];
			op_skip_reg_bit_high: skip_cond = REQ.rr_val[REQ.bit_sel];
			op_skip_io_bit_clear: skip_cond = ~REQ.io_val[REQ.bit_sel];
			op_skip_io_bit_high: skip_cond = REQ.io_val[REQ.bit_sel];
			default: skip_cond = 1'b0;
		endcase
	end

	always_comb begin
		m_asig = REQ.op inside {op_product_signed, op_product_signed_by_unsigned,
			op_fractional_product_signed, op_fractional_product_mixed};
		m_bsig = REQ.op inside {op_product_signed, op_fractional_product_signed};
		m_frac = REQ.op inside {op_fractional_product_unsigned,
			op_fractional_product_signed, op_fractional_product_mixed};
	end

	bme_mult u_mult (
		.a        (REQ.rd_val),
		.b        (REQ.rr_val),
		.a_signed (m_asig),
		.b_signed (m_bsig),
		.frac     (m_frac),
		.prod     (m_prod),
		.zero     (m_zero),
		.carry    (m_carry)
	);

	////////////////////////////////////////////////////////////////////////////
	// request decode and sequencing

	always_comb begin
		next_busy = busy;
		next_done = 1'b0;
		next_cnt  = cnt;
		next_res  = res;
		cyc       = CYC_CMP;
		if (busy) begin
			if (cnt == 2'h0) begin
				next_busy = 1'b0;
				next_done = 1'b1;
			end else begin
				next_cnt = cnt - 2'h1;
			end
		end else if (START) begin
			next_res         = '0;
			next_res.flags   = REQ.flags;
			next_res.pc      = REQ.pc + PC_STEP_ONE;
			unique case (REQ.op)
				op_product_unsigned, op_product_signed, op_product_signed_by_unsigned,
				op_fractional_product_unsigned, op_fractional_product_signed,
				op_fractional_product_mixed: begin
					cyc                    = CYC_PRODUCT;
					next_res.product       = m_prod;
					next_res.prod_we       = 1'b1;
					next_res.flags[FLAG_Z] = m_zero;
					next_res.flags[FLAG_C] = m_carry;
				end
				op_relative_jump: begin
					cyc         = CYC_JUMP_REL;
					next_res.pc = rel_target;
				end
				op_pointer_jump: begin
					cyc         = CYC_JUMP_FAR;
					next_res.pc = REQ.z_ptr;
				end
				op_absolute_jump: begin
					cyc         = CYC_JUMP_FAR;
					next_res.pc = REQ.abs_addr;
				end
				op_relative_subroutine_entry, op_pointer_subroutine_entry: begin
					cyc                = CYC_CALL_NEAR;
					next_res.push_en   = 1'b1;
					next_res.push_addr = REQ.pc + PC_STEP_ONE;
					next_res.pc = (REQ.op == op_relative_subroutine_entry) ? rel_target
						: REQ.z_ptr;
				end
				op_direct_subroutine_entry: begin
					cyc                = CYC_CALL_FAR;
					next_res.push_en   = 1'b1;
					next_res.push_addr = REQ.pc + PC_STEP_TWO;
					next_res.pc        = REQ.abs_addr;
				end
				op_subroutine_exit, op_handler_exit: begin
					cyc             = CYC_EXIT;
					next_res.pop_en = 1'b1;
					next_res.pc     = REQ.stack_pc;
					if (REQ.op == op_handler_exit) begin
						next_res.flags[FLAG_I] = 1'b1;
					end
				end
				op_register_compare: begin
					next_res.flags = compare_flags(REQ.flags, REQ.rd_val, REQ.rr_val, 1'b0);
				end
				op_compare_with_borrow: begin
					next_res.flags = compare_flags(REQ.flags, REQ.rd_val, REQ.rr_val, 1'b1);
				end
				op_immediate_compare: begin
					next_res.flags = compare_flags(REQ.flags, REQ.rd_val, REQ.imm, 1'b0);
				end
				op_equal_compare_skip, op_skip_reg_bit_clear, op_skip_reg_bit_high,
				op_skip_io_bit_clear, op_skip_io_bit_high: begin
					// skip over one or two words
					if (skip_cond) begin
						cyc         = REQ.next_two_word ? CYC_SKIP_TWO : CYC_SKIP_ONE;
						next_res.pc = REQ.pc + (REQ.next_two_word ? PC_STEP_THR : PC_STEP_TWO);
					end
				end
				default: begin
					if (br_taken) begin
						cyc         = CYC_BR_TAKEN;
						next_res.pc = rel_target;
					end else begin
						cyc = CYC_BR_NOT;
					end
				end
			endcase
			if (cyc == CYC_CMP) begin
				next_done = 1'b1;
			end else begin
				next_busy = 1'b1;
				next_cnt  = 2'(cyc - 3'h2);
			end
		end
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			busy <= 1'b0;
			done <= 1'b0;
			cnt  <= 2'h0;
			res  <= '0;
		end else begin
			busy <= next_busy;
			done <= next_done;
			cnt  <= next_cnt;
			res  <= next_res;
		end
	end

	assign BUSY = busy;
	assign DONE = done;
	assign RES  = res;

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);

	sequence taken_s;
		accept ##0 (REQ.op inside {[op_branch_flag_high:op_branch_halfcarry_low]}) ##0 br_taken;
	endsequence
	sequence not_taken_s;
		accept ##0 (REQ.op inside {[op_branch_flag_high:op_branch_halfcarry_low]}) ##0 !br_taken;
	endsequence

	product_two_a: assert property (accept && !m_frac
		&& REQ.op inside {op_product_unsigned, op_product_signed, op_product_signed_by_unsigned}
		|-> ##1 (!DONE && BUSY) ##1 (DONE && RES.prod_we && !BUSY))
		else $error("integer multiply did not finish in two cycles");
	frac_shift_a: assert property (accept && m_frac |-> ##2 (DONE && !RES.product[0]))
		else $error("fractional product not shifted or late");
	rel_jump_a: assert property (accept && REQ.op == op_relative_jump
		|-> ##2 (DONE && RES.pc == $past(rel_target, 2)))
		else $error("relative jump target or timing wrong");
	call_push_a: assert property (accept && REQ.op == op_direct_subroutine_entry
		|-> ##1 RES.push_en ##0 (RES.push_addr == $past(REQ.pc) + PC_STEP_TWO) ##3 DONE)
		else $error("direct call push or timing wrong");
	exit_irq_a: assert property (accept && REQ.op == op_handler_exit
		|-> ##4 (DONE && RES.flags[FLAG_I] && RES.pop_en))
		else $error("handler exit did not restore interrupt enable in four");
	cmp_one_a: assert property (accept && REQ.op inside {op_register_compare,
		op_compare_with_borrow, op_immediate_compare}
		|-> ##1 (DONE && RES.pc == $past(REQ.pc) + PC_STEP_ONE))
		else $error("compare not single cycle");
	skip_two_a: assert property (accept && skip_cond && REQ.next_two_word
		|-> ##3 (DONE && RES.pc == $past(REQ.pc, 3) + PC_STEP_THR
			&& RES.flags == $past(REQ.flags, 3)))
		else $error("skip over two-word instruction wrong");
	br_taken_a: assert property (taken_s |-> ##2 (DONE && RES.flags == $past(REQ.flags, 2)))
		else $error("taken branch not two cycles or flags changed");
	br_not_a: assert property (not_taken_s |-> ##1 (DONE && RES.pc == $past(REQ.pc) + PC_STEP_ONE))
		else $error("untaken branch not one cycle");

endmodule

// ==== sim/bme_core_model.sv ====
// model of the core around the unit: the R1:R0 pair and the stack top.
// assumes DONE and RES come from the unit; RES is read mid-cycle.
`timescale 1ns/100ps
module bme_core_model import bme_pkg::*; (
	input  wire logic        ref_clk,
	input  wire logic        done,
	input  wire bme_res_type res,
	output logic      [15:0] pair,
	output logic      [15:0] stack_top
);
	initial begin
		pair = 16'h0000;
		stack_top = 16'h0000;
	end
	always @(negedge ref_clk) begin
		if (done && res.prod_we)
			pair <= res.product;
		if (done && res.push_en)
			stack_top <= res.push_addr;
	end
endmodule

// ==== sim/tb_top.sv ====
// testbench for the execution unit: one task per instruction group.
// assumes the core model stores products and pushes; no other partner.
`timescale 1ns/100ps
module tb_top import bme_pkg::*;;
	logic        ref_clk;
	logic        rst;
	logic        start;
	bme_req_type req;
	logic        busy;
	logic        done;
	bme_res_type res;
	logic [15:0] pair;
	logic [15:0] stk;
	int          err_count;
	int          tests_run;
	int          n;

	bme_exec uut (.REF_CLK(ref_clk), .RST(rst), .START(start), .REQ(req), .BUSY(busy),
		.DONE(done), .RES(res));
	bme_core_model mdl (.ref_clk(ref_clk), .done(done), .res(res), .pair(pair),
		.stack_top(stk));

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	function automatic bme_req_type mk(input int k);
		mk = '0;
		mk.op = bme_op_type'(k);
		mk.pc = 16'h1000;
		mk.flags = 8'h25;
		mk.offset = 12'hffe;
		mk.z_ptr = 16'h2345;
		mk.abs_addr = 16'h3456;
		mk.stack_pc = 16'h4567;
	endfunction

	// n counts edges from the taking edge to the one that raises done
	task automatic issue(input bme_req_type r);
		@(posedge ref_clk);
		start <= 1'b1;
		req <= r;
		@(posedge ref_clk);
		start <= 1'b0;
		n = 1;
		#1;
		while (done !== 1'b1 && n < 9) begin
			@(posedge ref_clk);
			n++;
			#1;
		end
		@(negedge ref_clk);
		#1;
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_product;
		bme_req_type r;
		int pa;
		int pb;
		int p;
		logic [15:0] e;
		logic c;
		for (int j = 0; j < 2; j++) begin
			for (int i = 0; i < 6; i++) begin
				r = mk(i);
				r.rd_val = j ? 8'h00 : 8'hc0;
				r.rr_val = 8'h82;
				pa = r.rd_val;
				pb = r.rr_val;
				if (i == 1 || i == 2 || i == 4 || i == 5)
					pa = $signed(r.rd_val);
				if (i == 1 || i == 4)
					pb = $signed(r.rr_val);
				p = pa * pb;
				e = p[15:0];
				c = e[15];
				if (i >= 3)
					e = e << 1;
				issue(r);
				chk("product cycles", n, 2);
				chk("product value", res.product, e);
				chk("product pair", pair, e);
				chk("product flags", res.flags, {6'h09, e == 16'h0000, c});
			end
		end
		$display("test multiply done");
	endtask

	task automatic t_flow;
		bme_req_type r;
		logic [15:0] tgt [3] = '{16'h0fff, 16'h2345, 16'h3456};
		for (int i = 0; i < 6; i++) begin
			r = mk(6 + i);
			issue(r);
			chk("flow pc", res.pc, tgt[i % 3]);
			chk("flow flags", res.flags, 8'h25);
			chk("flow push", res.push_en, i > 2);
			chk("flow cycles", n, i == 0 ? 2 : (i == 5 ? 4 : 3));
			if (i > 2)
				chk("push addr", stk, i == 5 ? 16'h1002 : 16'h1001);
		end
		for (int i = 0; i < 2; i++) begin
			issue(mk(12 + i));
			chk("exit pc", res.pc, 16'h4567);
			chk("exit flags", res.flags, i ? 8'ha5 : 8'h25);
			chk("exit cycles", n, 4);
			chk("exit pop", res.pop_en, 1'b1);
		end
		$display("test flow done");
	endtask

	// a jump held on START while a direct call runs is taken on the edge after DONE rises
	task automatic t_held;
		@(posedge ref_clk);
		start <= 1'b1;
		req <= mk(11);
		@(posedge ref_clk);
		req <= mk(6);
		repeat (3) @(posedge ref_clk);
		#1;
		chk("held call done", done, 1'b1);
		chk("held call busy", busy, 1'b0);
		chk("held call pc", res.pc, 16'h3456);
		@(posedge ref_clk);
		start <= 1'b0;
		#1;
		chk("queued jump busy", busy, 1'b1);
		chk("queued jump early", done, 1'b0);
		chk("queued jump pc", res.pc, 16'h0fff);
		@(posedge ref_clk);
		#1;
		chk("queued jump done", done, 1'b1);
		chk("queued jump idle", busy, 1'b0);
		@(negedge ref_clk);
		$display("test held request done");
	endtask

	function automatic logic [7:0] cmpf(input logic [7:0] d, input logic [7:0] r,
		input logic [7:0] s, input logic wc);
		logic [7:0] x;
		logic v;
		x = d - r - {7'h00, wc & s[0]};
		v = (d[7] & ~r[7] & ~x[7]) | (~d[7] & r[7] & x[7]);
		cmpf = s;
		cmpf[0] = (~d[7] & r[7]) | (r[7] & x[7]) | (x[7] & ~d[7]);
		cmpf[1] = (x == 8'h00) & (~wc | s[1]);
		cmpf[2] = x[7];
		cmpf[3] = v;
		cmpf[4] = x[7] ^ v;
		cmpf[5] = (~d[3] & r[3]) | (r[3] & x[3]) | (x[3] & ~d[3]);
	endfunction

	task automatic t_cmp;
		bme_req_type r;
		int          ops [4] = '{15, 16, 16, 17};
		logic [7:0]  dv [4] = '{8'h10, 8'h10, 8'h10, 8'h05};
		logic [7:0]  rv [4] = '{8'h10, 8'h0f, 8'h0f, 8'h80};
		logic [7:0]  sv [4] = '{8'h25, 8'h03, 8'h01, 8'h25};
		for (int i = 0; i < 4; i++) begin
			r = mk(ops[i]);
			r.rd_val = dv[i];
			r.rr_val = rv[i];
			r.imm = rv[i];
			r.flags = sv[i];
			issue(r);
			chk("cmp flags", res.flags, cmpf(dv[i], rv[i], sv[i], i == 1 || i == 2));
			chk("cmp cycles", n, 1);
			chk("cmp store", res.prod_we, 1'b0);
		end
		$display("test compare done");
	endtask

	task automatic t_skip;
		bme_req_type r;
		int ops [5] = '{14, 18, 19, 20, 21};
		logic [7:0] v;
		for (int i = 0; i < 20; i++) begin
			r = mk(ops[i / 4]);
			r.bit_sel = 3'h3;
			r.next_two_word = i[0];
			v = (i[1] ^ (i / 4 == 1 || i / 4 == 3)) ? 8'h08 : 8'h00;
			r.rd_val = 8'h5a;
			r.rr_val = i < 4 ? (i[1] ? 8'h5a : 8'h5b) : v;
			r.io_val = v;
			if (i >= 4)
				r.rd_val = v;
			issue(r);
			chk("skip pc", res.pc, 16'h1001 + (i[1] ? {15'h0, i[0]} + 16'h1 : 16'h0));
			chk("skip cycles", n, i[1] ? 2 + i[0] : 1);
			chk("skip flags", res.flags, 8'h25);
		end
		$display("test skip done");
	endtask

	task automatic t_branch;
		bme_req_type r;
		logic [7:0] sv [3] = '{8'h00, 8'h2f, 8'h04};
		logic [7:0] s;
		logic t;
		for (int k = 22; k < 36; k++) begin
			for (int j = 0; j < 3; j++) begin
				r = mk(k);
				s = sv[j];
				r.flags = s;
				r.offset = 12'hff0;
				r.bit_sel = 3'h2;
				case (k)
					22, 23: t = s[2];
					24, 25: t = s[1];
					26, 27, 28, 29: t = s[0];
					30, 31: t = s[2];
					32, 33: t = s[2] ^ s[3];
					default: t = s[5];
				endcase
				if (k == 23 || k == 25 || k == 27 || k == 28 || k == 31 || k == 32 || k == 35)
					t = ~t;
				issue(r);
				chk("branch pc", res.pc, t ? 16'h0ff1 : 16'h1001);
				chk("branch cycles", n, t ? 2 : 1);
				chk("branch flags", res.flags, s);
			end
		end
		$display("test branch done");
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic conclude;
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		#100000;
		err_count++;
		conclude();
	end

	initial begin
		err_count = 0;
		tests_run = 0;
		start = 1'b0;
		req = '0;
		rst = 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		#1;
		chk("reset done", done, 1'b0);
		chk("reset busy", busy, 1'b0);
		t_product();
		t_flow();
		t_held();
		t_cmp();
		t_skip();
		t_branch();
		conclude();
	end
endmodule
